// ---- logic/serpk_packer.v ----
// Function
// - receive logic runs only while the channel link enable bit is one
// - interpolated bits 3..0 land in low word bits 3..0
// - single-turn bits 13..0 land in low word bits 17..4
// - multi-turn correction bits land in low word bits 19..18
// - turn count 11..0 to low word 31..20, 15..12 to high word 3..0
// - alarm code to high word 24..26: in-position, absolute, busy
// - own errors in high word 29..31: coding, crc, timeout
// - one two-way data pair; clock and enable outputs stay unused
// - bits recovered by oversampling at twenty times the bit rate
`timescale 1ns/1ps
`default_nettype none
`include "serpk_defs.vh"

module serpk_packer #(
  parameter SCLK_DIV = 1,
  parameter OVS = `SERPK_OVS,
  parameter TIMEOUT_TICKS = `SERPK_TIMEOUT_BITS * `SERPK_OVS
) (
  // clock, reset, enable
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // query trigger from the motion processor
  input wire trig_i,
  // encoder data pair
  input wire data_i,
  output reg data_o,
  output reg data_oe_o,
  // unused clock and enable pairs
  output reg link_clock_output_o,
  output reg link_enable_output_o,
  // interrupt
  output reg irq_o,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------
  // frame states
  // ----------------------------------------
  localparam ST_IDLE = 5'b00001;
  localparam ST_TX = 5'b00010;
  localparam ST_WAIT = 5'b00100;
  localparam ST_RX = 5'b01000;
  localparam ST_DONE = 5'b10000;

  function [7:0] serpk_crc_step;
    input [7:0] crc;
    input b;
    begin
      serpk_crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? `SERPK_CRC_POLY : 8'h00);
    end
  endfunction

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  reg [31:0] ctrl;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg [31:0] position_result_low_word;
  reg [31:0] position_result_high_word;
  reg [4:0] state;
  reg [15:0] div_cnt;
  reg tick;
  reg tx_go;
  reg [15:0] tmo_cnt;
  reg [5:0] bit_cnt;
  reg [38:0] pay_sh;
  reg [7:0] crc_calc;
  reg [7:0] crc_rx;
  reg code_err;
  reg stop_bit;
  reg tmo_err;
  reg ev_done;
  reg ev_err;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [31:0] rd_val;
  reg rd_ok;

  wire channel_link_enable;
  wire tx_dout;
  wire tx_oe;
  wire tx_done;
  wire rx_vld;
  wire rx_val;
  wire rx_err;
  wire rx_active;
  wire rx_arm;
  wire wr_fire;
  wire [31:0] status_word;

  assign channel_link_enable = ctrl[`SERPK_CTRL_EN_BIT];
  assign rx_arm = (state == ST_RX) || (state == ST_WAIT);
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign status_word = {30'h0, rx_active, (state != ST_IDLE)};

  // ----------------------------------------
  // serial sample clock enable
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (ce_i) begin
      if (div_cnt >= SCLK_DIV[15:0] - 16'h0001) begin
        div_cnt <= 16'h0000;
        tick <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
        tick <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // line transmitter and bit recovery
  // ----------------------------------------
  serpk_req_tx #(
    .OVS(OVS)
  ) u_tx (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(tick),
    .go_i(tx_go),
    .cmd_i(ctrl[`SERPK_CTRL_CMD_MSB:`SERPK_CTRL_CMD_LSB]),
    .dout_o(tx_dout),
    .oe_o(tx_oe),
    .done_o(tx_done)
  );

  serpk_bit_rx #(
    .OVS(OVS)
  ) u_rx (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(tick),
    .arm_i(rx_arm),
    .din_i(data_i),
    .bit_vld_o(rx_vld),
    .bit_val_o(rx_val),
    .bit_err_o(rx_err),
    .active_o(rx_active)
  );

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= 1'b1;
      data_oe_o <= 1'b0;
      link_clock_output_o <= 1'b0;
      link_enable_output_o <= 1'b0;
    end else if (ce_i) begin
      // only the data pair is ever driven
      data_o <= tx_dout;
      data_oe_o <= tx_oe;
      link_clock_output_o <= 1'b0;
      link_enable_output_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      tx_go <= 1'b0;
      tmo_cnt <= 16'h0000;
      bit_cnt <= 6'h00;
      pay_sh <= 39'h0;
      crc_calc <= `SERPK_CRC_INIT;
      crc_rx <= 8'h00;
      code_err <= 1'b0;
      stop_bit <= 1'b1;
      tmo_err <= 1'b0;
      ev_done <= 1'b0;
      ev_err <= 1'b0;
      position_result_low_word <= 32'h0000_0000;
      position_result_high_word <= 32'h0000_0000;
    end else if (ce_i) begin
      tx_go <= 1'b0;
      ev_done <= 1'b0;
      ev_err <= 1'b0;
      // disabling the channel sends the sequencer to idle; the transmitter still finishes a request already started
      if (!channel_link_enable) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            if (trig_i) begin
              tx_go <= 1'b1;
              state <= ST_TX;
            end
          end
          ST_TX: begin
            if (tx_done) begin
              tmo_cnt <= 16'h0000;
              bit_cnt <= 6'h00;
              crc_calc <= `SERPK_CRC_INIT;
              code_err <= 1'b0;
              tmo_err <= 1'b0;
              state <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (rx_active) begin
              state <= ST_RX;
            end else if (tick) begin
              if (tmo_cnt == TIMEOUT_TICKS[15:0] - 16'h0001) begin
                tmo_err <= 1'b1;
                state <= ST_DONE;
              end else begin
                tmo_cnt <= tmo_cnt + 16'h0001;
              end
            end
          end
          ST_RX: begin
            if (rx_vld) begin
              if (rx_err) begin
                code_err <= 1'b1;
              end
              if (bit_cnt == 6'h00) begin
                if (rx_val) begin
                  code_err <= 1'b1;
                end
              end else if (bit_cnt <= `SERPK_PAYLOAD_BITS) begin
                pay_sh <= {rx_val, pay_sh[38:1]};
                crc_calc <= serpk_crc_step(crc_calc, rx_val);
              end else if (bit_cnt <= `SERPK_PAYLOAD_BITS + `SERPK_CRC_BITS) begin
                crc_rx <= {rx_val, crc_rx[7:1]};
              end else begin
                stop_bit <= rx_val;
              end
              if (bit_cnt == `SERPK_FRAME_BITS - 1) begin
                state <= ST_DONE;
              end
              bit_cnt <= bit_cnt + 6'h01;
            end
          end
          ST_DONE: begin
            // both words written in the same cycle
            if (tmo_err) begin
              // a lost frame keeps the last position and flags only the timeout
              position_result_high_word[`SERPK_ETIME_BIT] <= 1'b1;
              position_result_high_word[`SERPK_ECRC_BIT] <= 1'b0;
              position_result_high_word[`SERPK_ECODE_BIT] <= 1'b0;
              position_result_low_word <= position_result_low_word;
              ev_err <= 1'b1;
            end else begin
              position_result_low_word[`SERPK_INTERP_MSB:`SERPK_INTERP_LSB] <= pay_sh[3:0];
              position_result_low_word[`SERPK_SINGLE_MSB:`SERPK_SINGLE_LSB] <= pay_sh[17:4];
              position_result_low_word[`SERPK_CORR_MSB:`SERPK_CORR_LSB] <= pay_sh[19:18];
              // turn count split over both words
              position_result_low_word[`SERPK_MTLO_MSB:`SERPK_MTLO_LSB] <= pay_sh[31:20];
              position_result_high_word <= 32'h0000_0000;
              position_result_high_word[`SERPK_MTHI_MSB:`SERPK_MTHI_LSB] <= pay_sh[35:32];
              position_result_high_word[`SERPK_ALARM_MSB:`SERPK_ALARM_LSB] <= pay_sh[38:36];
              position_result_high_word[`SERPK_ECODE_BIT] <= code_err || !stop_bit;
              position_result_high_word[`SERPK_ECRC_BIT] <= (crc_rx != crc_calc);
              position_result_high_word[`SERPK_ETIME_BIT] <= 1'b0;
              ev_err <= code_err || !stop_bit || (crc_rx != crc_calc);
            end
            ev_done <= 1'b1;
            state <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `SERPK_CTRL_OFS: rd_val = ctrl;
      `SERPK_STAT_OFS: rd_val = status_word;
      `SERPK_IRQ_STAT_OFS: rd_val = {30'h0, irq_stat};
      `SERPK_IRQ_MASK_OFS: rd_val = {30'h0, irq_mask};
      `SERPK_LOW_OFS: rd_val = position_result_low_word;
      `SERPK_HIGH_OFS: rd_val = position_result_high_word;
      default: rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SERPK_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SERPK_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= `SERPK_CTRL_RST;
      irq_mask <= `SERPK_MASK_RST;
      irq_stat <= 2'h0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      // address and data are taken in either order, one write at a time
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wready && s_axi_wvalid) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SERPK_RESP_OKAY;
        case (aw_addr)
          `SERPK_CTRL_OFS: begin
            if (w_strb[0]) begin
              ctrl[`SERPK_CTRL_EN_BIT] <= w_data[`SERPK_CTRL_EN_BIT];
            end
            if (w_strb[1]) begin
              ctrl[`SERPK_CTRL_CMD_MSB:`SERPK_CTRL_CMD_LSB] <= w_data[`SERPK_CTRL_CMD_MSB:`SERPK_CTRL_CMD_LSB];
            end
          end
          `SERPK_IRQ_MASK_OFS: begin
            if (w_strb[0]) begin
              irq_mask <= w_data[1:0];
            end
          end
          `SERPK_IRQ_STAT_OFS, `SERPK_STAT_OFS, `SERPK_LOW_OFS, `SERPK_HIGH_OFS: begin
            s_axi_bresp <= `SERPK_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `SERPK_RESP_SLVERR;
          end
        endcase
      end
      // sticky events: a new event wins over a write-one clear
      irq_stat[`SERPK_IRQ_DONE_BIT] <= ev_done || (irq_stat[`SERPK_IRQ_DONE_BIT]
        && !(wr_fire && aw_addr == `SERPK_IRQ_STAT_OFS && w_strb[0] && w_data[`SERPK_IRQ_DONE_BIT]));
      irq_stat[`SERPK_IRQ_ERR_BIT] <= ev_err || (irq_stat[`SERPK_IRQ_ERR_BIT]
        && !(wr_fire && aw_addr == `SERPK_IRQ_STAT_OFS && w_strb[0] && w_data[`SERPK_IRQ_ERR_BIT]));
      irq_o <= |(irq_stat & irq_mask);
      // read path: one read at a time, answer one cycle after address is taken
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `SERPK_RESP_OKAY : `SERPK_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // serpk_packer
`default_nettype wire

// ---- logic/serpk_defs.vh ----
`ifndef SERPK_DEFS_VH
`define SERPK_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SERPK_CTRL_OFS 8'h00
`define SERPK_STAT_OFS 8'h04
`define SERPK_IRQ_STAT_OFS 8'h08
`define SERPK_IRQ_MASK_OFS 8'h0c
`define SERPK_LOW_OFS 8'h10
`define SERPK_HIGH_OFS 8'h14

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define SERPK_CTRL_EN_BIT 0
`define SERPK_CTRL_CMD_LSB 8
`define SERPK_CTRL_CMD_MSB 15
`define SERPK_CTRL_RST 32'h0000_0000
`define SERPK_MASK_RST 2'h0

// ----------------------------------------
// status and interrupt fields
// ----------------------------------------
`define SERPK_STAT_BUSY_BIT 0
`define SERPK_STAT_RX_BIT 1
`define SERPK_IRQ_DONE_BIT 0
`define SERPK_IRQ_ERR_BIT 1

// ----------------------------------------
// result word layout
// ----------------------------------------
`define SERPK_INTERP_MSB 3
`define SERPK_INTERP_LSB 0
`define SERPK_SINGLE_MSB 17
`define SERPK_SINGLE_LSB 4
`define SERPK_CORR_MSB 19
`define SERPK_CORR_LSB 18
`define SERPK_MTLO_MSB 31
`define SERPK_MTLO_LSB 20
`define SERPK_MTHI_MSB 3
`define SERPK_MTHI_LSB 0
`define SERPK_ALARM_MSB 26
`define SERPK_ALARM_LSB 24
`define SERPK_ECODE_BIT 29
`define SERPK_ECRC_BIT 30
`define SERPK_ETIME_BIT 31

// ----------------------------------------
// frame and timing counts
// ----------------------------------------
`define SERPK_OVS 20
`define SERPK_PAYLOAD_BITS 39
`define SERPK_CRC_BITS 8
`define SERPK_FRAME_BITS 49
`define SERPK_TX_BITS 10
`define SERPK_TIMEOUT_BITS 64
`define SERPK_CRC_POLY 8'h07
`define SERPK_CRC_INIT 8'h00

// ----------------------------------------
// bus responses
// ----------------------------------------
`define SERPK_RESP_OKAY 2'b00
`define SERPK_RESP_SLVERR 2'b10

`endif

// ---- logic/serpk_bit_rx.v ----
`timescale 1ns/1ps
`default_nettype none
`include "serpk_defs.vh"

module serpk_bit_rx #(
  parameter OVS = `SERPK_OVS
) (
  // clock, reset, enable
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // control
  input wire tick_i,
  input wire arm_i,
  input wire din_i,
  // recovered bits
  output reg bit_vld_o,
  output reg bit_val_o,
  output reg bit_err_o,
  output reg active_o
);

  reg s1;
  reg s2;
  reg s3;
  reg lvl;
  reg early;
  reg [7:0] cnt;

  // ----------------------------------------
  // oversampled bit recovery
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      lvl <= 1'b1;
      early <= 1'b1;
      cnt <= 8'h00;
      bit_vld_o <= 1'b0;
      bit_val_o <= 1'b1;
      bit_err_o <= 1'b0;
      active_o <= 1'b0;
    end else if (ce_i) begin
      s1 <= din_i;
      s2 <= s1;
      s3 <= s2;
      // a change counts only once two stages agree
      if (s2 == s3) begin
        lvl <= s3;
      end
      bit_vld_o <= 1'b0;
      if (!arm_i) begin
        active_o <= 1'b0;
        cnt <= 8'h00;
      end else if (tick_i) begin
        if (!active_o) begin
          if (!lvl) begin
            active_o <= 1'b1;
            cnt <= 8'h01;
          end
        end else begin
          if (cnt == OVS / 4) begin
            early <= lvl;
          end
          if (cnt == OVS / 2) begin
            bit_val_o <= lvl;
          end
          if (cnt == (3 * OVS) / 4) begin
            bit_err_o <= (lvl != early);
          end
          if (cnt == OVS - 1) begin
            bit_vld_o <= 1'b1;
            cnt <= 8'h00;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
      end
    end
  end

endmodule // serpk_bit_rx
`default_nettype wire

// ---- logic/serpk_req_tx.v ----
`timescale 1ns/1ps
`default_nettype none
`include "serpk_defs.vh"

module serpk_req_tx #(
  parameter OVS = `SERPK_OVS
) (
  // clock, reset, enable
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // request
  input wire tick_i,
  input wire go_i,
  input wire [7:0] cmd_i,
  // line drive
  output reg dout_o,
  output reg oe_o,
  output reg done_o
);

  reg [9:0] sh;
  reg [3:0] nbit;
  reg [7:0] cnt;

  // ----------------------------------------
  // start bit, command lsb first, stop bit
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh <= 10'h3ff;
      nbit <= 4'h0;
      cnt <= 8'h00;
      dout_o <= 1'b1;
      oe_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (go_i && !oe_o) begin
        sh <= {1'b1, cmd_i, 1'b0};
        oe_o <= 1'b1;
        dout_o <= 1'b1;
        nbit <= 4'h0;
        cnt <= 8'h00;
      end else if (oe_o && tick_i) begin
        if (cnt == 8'h00) begin
          dout_o <= sh[0];
          sh <= {1'b1, sh[9:1]};
        end
        if (cnt == OVS - 1) begin
          cnt <= 8'h00;
          if (nbit == `SERPK_TX_BITS - 1) begin
            // release the pair so the encoder can answer
            oe_o <= 1'b0;
            done_o <= 1'b1;
          end
          nbit <= nbit + 4'h1;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end

endmodule // serpk_req_tx
`default_nettype wire

// ---- tb/serpk_packer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "serpk_defs.vh"

module serpk_packer_properties #(
  parameter int OVS = 20,
  parameter int SCLK_DIV = 1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link side
  input wire logic data_o,
  input wire logic data_oe_o,
  input wire logic link_clock_output_o,
  input wire logic link_enable_output_o,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int BIT = OVS * SCLK_DIV;
  logic [7:0] aw_q;
  logic w_q;
  logic en_q;
  logic hi_rd;
  int oe_cnt;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // shadow of enable, taken late (at the answer) so it never leads the design
  // ----
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_q <= 8'h00;
      w_q <= 1'b0;
      en_q <= 1'b0;
      hi_rd <= 1'b0;
      oe_cnt <= 0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[0];
      if (s_axi_bvalid && s_axi_bready && aw_q == `SERPK_CTRL_OFS) en_q <= w_q;
      if (s_axi_arvalid && s_axi_arready) hi_rd <= (s_axi_araddr == `SERPK_HIGH_OFS);
      oe_cnt <= data_oe_o ? oe_cnt + 1 : 0;
    end
  end
  sequence s_start_bit;
    !data_o [*8];
  endsequence
  sequence s_stop_bit;
    $past(data_o);
  endsequence
  link_unused_a: assert property (!link_clock_output_o && !link_enable_output_o)
    else $error("clock or enable output driven");
  req_start_a: assert property ($rose(data_oe_o) |=> s_start_bit)
    else $error("request lacks start bit");
  req_len_a: assert property ($fell(data_oe_o) && en_q |-> oe_cnt == `SERPK_TX_BITS * BIT ##0 s_stop_bit)
    else $error("request length or stop bit wrong");
  bit_edge_a: assert property (data_oe_o && $past(data_oe_o) && $changed(data_o) |-> oe_cnt % BIT == 1)
    else $error("request bit edge off the bit grid");
  off_quiet_a: assert property (!en_q [*4] |-> !data_oe_o)
    else $error("pair driven while disabled");
  high_unused_a: assert property (s_axi_rvalid && hi_rd |-> s_axi_rdata[23:4] == 20'h0 && s_axi_rdata[28:27] == 2'h0)
    else $error("unused high word bits set");
  timeout_alone_a: assert property (s_axi_rvalid && hi_rd && s_axi_rdata[31] |-> s_axi_rdata[30:29] == 2'h0)
    else $error("timeout with other error bits");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
endmodule // serpk_packer_properties

bind serpk_packer serpk_packer_properties #(.OVS(OVS), .SCLK_DIV(SCLK_DIV)) u_props (.*);
`default_nettype wire

// ---- tb/serpk_enc_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module serpk_enc_model #(
  parameter int BIT = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request side and reply control
  input wire logic req_oe_i,
  input wire logic [38:0] pay_i,
  input wire logic [1:0] mode_i,
  input wire logic [9:0] dly_i,
  // reply line
  output logic line_o
);
  logic [7:0] crc;
  task automatic send(input logic b);
    line_o <= b;
    repeat (BIT) @(posedge clk_i);
  endtask
  // mode 1 bad check, 2 silent, 3 stop low; released pair idles high (failsafe bias)
  initial begin
    line_o = 1'b1;
    @(posedge rst_n_i);
    forever begin
      @(negedge req_oe_i);
      if (mode_i != 2'd2) begin
        repeat (dly_i) @(posedge clk_i);
        crc = 8'h00;
        send(1'b0);
        for (int i = 0; i < 39; i++) begin
          send(pay_i[i]);
          crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ pay_i[i]) ? 8'h07 : 8'h00);
        end
        for (int i = 0; i < 8; i++) send(crc[i] ^ (mode_i == 2'd1 && i == 0));
        send(mode_i != 2'd3);
        line_o <= 1'b1;
      end
    end
  end
endmodule // serpk_enc_model
`default_nettype wire

// ---- tb/tb_serpk_packer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "serpk_defs.vh"

module tb_serpk_packer;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic trig_i = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_o, d_o, d_oe, line, pair;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [38:0] pay = 39'h0;
  logic [1:0] mode = 2'd0;
  logic [9:0] dly = 10'd10;
  int checks = 0;
  int n_mismatch = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  assign pair = d_oe ? d_o : line;
  serpk_packer #(.SCLK_DIV(1), .OVS(20), .TIMEOUT_TICKS(400)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .trig_i(trig_i),
    .data_i(pair), .data_o(d_o), .data_oe_o(d_oe),
    .link_clock_output_o(), .link_enable_output_o(), .irq_o(irq_o),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  serpk_enc_model #(.BIT(20)) u_enc (
    .clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_oe_i(d_oe), .pay_i(pay),
    .mode_i(mode), .dly_i(dly), .line_o(line));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic pa, pw;
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    for (n = 0; n < 99; n++) begin
      #1;
      if (awready) pa = 1'b0;
      if (wready) pw = 1'b0;
      if (bvalid) break;
      @(posedge ref_clk_i);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
    end
    r = bresp;
    @(posedge ref_clk_i);
    bready <= 1'b0;
    if (n == 99) begin
      chk("write answer", 0, 1);
      test_done;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic pa;
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    for (n = 0; n < 99; n++) begin
      #1;
      if (arready) pa = 1'b0;
      if (rvalid) break;
      @(posedge ref_clk_i);
      if (!pa) arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    @(posedge ref_clk_i);
    rready <= 1'b0;
    if (n == 99) begin
      chk("read answer", 0, 1);
      test_done;
    end
  endtask
  task automatic fire;
    @(posedge ref_clk_i);
    trig_i <= 1'b1;
    @(posedge ref_clk_i);
    trig_i <= 1'b0;
  endtask
  task automatic wait_irq(input int lim);
    for (int n = 0; n < lim && irq_o !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk("irq raised", 1, irq_o);
    if (irq_o !== 1'b1) test_done;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(`SERPK_CTRL_OFS, d, r);
    chk("ctrl reset", `SERPK_CTRL_RST, d);
    rd(`SERPK_IRQ_MASK_OFS, d, r);
    chk("mask reset", {30'h0, `SERPK_MASK_RST}, d);
    rd(8'h40, d, r);
    chk("unmapped rresp", `SERPK_RESP_SLVERR, r);
    chk("unmapped rdata", 0, d);
    wr(8'h40, 32'hffff_ffff, r);
    chk("unmapped bresp", `SERPK_RESP_SLVERR, r);
    $display("t_regs done");
  endtask
  task automatic t_off;
    logic seen;
    seen = 1'b0;
    fire;
    repeat (300) begin
      @(posedge ref_clk_i);
      seen = seen | (d_oe === 1'b1);
    end
    chk("pair driven while off", 0, seen);
    $display("t_off done");
  endtask
  task automatic t_frame;
    logic [31:0] d;
    logic [1:0] r;
    logic [38:0] pv [2];
    pv = '{39'h6b_d2c4_1e95, 39'h7f_ffff_ffff};
    wr(`SERPK_IRQ_MASK_OFS, 32'h1, r);
    wr(`SERPK_CTRL_OFS, 32'h0000_0101, r);
    ce <= 1'b0;
    fire;
    ce <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk("ce freeze", 0, d_oe);
    for (int i = 0; i < 2; i++) begin
      pay = pv[i];
      dly = (i == 0) ? 10'd10 : 10'd350;
      fire;
      wait_irq(2000);
      rd(`SERPK_LOW_OFS, d, r);
      chk("low word", pv[i][31:0], d);
      rd(`SERPK_HIGH_OFS, d, r);
      chk("high word", {5'h0, pv[i][38:36], 20'h0, pv[i][35:32]}, d);
      wr(`SERPK_IRQ_STAT_OFS, 32'h3, r);
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk("irq cleared", 0, irq_o);
    end
    $display("t_frame done");
  endtask
  task automatic t_err;
    logic [31:0] d;
    logic [1:0] r;
    logic [1:0] md [3];
    logic [2:0] ex [3];
    md = '{2'd2, 2'd1, 2'd3};
    ex = '{3'b100, 3'b010, 3'b001};
    for (int i = 0; i < 3; i++) begin
      wr(`SERPK_IRQ_MASK_OFS, 32'h0, r);
      mode = md[i];
      dly = 10'd10;
      fire;
      d = 32'h0;
      for (int n = 0; n < 800 && d[1] !== 1'b1; n++) rd(`SERPK_IRQ_STAT_OFS, d, r);
      #1;
      chk("error flag", 1, d[1]);
      if (d[1] !== 1'b1) test_done;
      chk("irq masked", 0, irq_o);
      wr(`SERPK_IRQ_MASK_OFS, 32'h2, r);
      wait_irq(4);
      rd(`SERPK_HIGH_OFS, d, r);
      chk("error bits", ex[i], d[31:29]);
      rd(`SERPK_LOW_OFS, d, r);
      if (i == 0) chk("low kept", 32'hffff_ffff, d);
      wr(`SERPK_IRQ_STAT_OFS, 32'h3, r);
    end
    $display("t_err done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_off;
    t_frame;
    t_err;
    test_done;
  end
endmodule // tb_serpk_packer
`default_nettype wire
